// >>> verilog/scc_clock_select.sv
// system clock select control: registers, source resolution, status and sleep entry
//
// Behaviour
// RULE1 - six clock modes; five from configuration, slow rc entered by software or default
// RULE2 - idle select bit 7 makes sleep request enter idle, else full sleep
// RULE3 - fast rc select 111 is 8 MHz, halving down to 125 kHz; 000 is 31 kHz
// RULE4 - changing fast rc select while fast rc clocks takes effect at once
// RULE5 - start-up bit reads 1 once timer expired and primary clocks the part
// RULE6 - start-up bit value after reset follows the two-speed configuration bit; the code loads the inverse of that bit
// RULE7 - fast rc stable bit resets 0, reads 1 when fast rc is stable
// RULE8 - source select 11 internal, 10 primary, 01 secondary oscillator
// RULE9 - source select 00 picks primary or internal by default clock config
// RULE10 - a write changing source select starts a clock switch at once
// RULE11 - the new source takes over only after a short transition interval
// RULE12 - low-frequency select picks fast rc divided by 256 or slow rc
// RULE13 - multiplier enable bit 6 works only in multiplied modes, else reads 0
// RULE14 - six-bit signed trim; 011111 max, 000000 centre, 100000 min
// RULE15 - in power-managed modes start-up and secondary-active bits never both set
// RULE16 - secondary selection is ignored while the secondary oscillator is disabled
// RULE17 - software should start the secondary oscillator before selecting it for sleep
// RULE18 - slow rc keeps clocking watchdog and monitor regardless of selected source
// RULE19 - secondary oscillator may keep running in power-managed modes
// RULE20 - source select clears to 00 on every reset
// RULE21 - switch pauses two old-source cycles plus three new-source cycles
// RULE22 - multiplier gives four times the external source in multiplied modes
// RULE23 - source edges are synchronised before the switch sequencer uses them
//
// The implementer's own choices: the register offsets and the plain strobed port.
module scc_clock_select
  import scc_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire logic [SCC_ADDR_W-1:0] reg_addr,
  input  wire logic [SCC_DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic      [SCC_DATA_W-1:0] reg_rdata,
  input  wire logic [2:0]            primary_mode_config,
  input  wire logic                  default_clock_config,
  input  wire logic                  two_speed_start_config,
  input  wire logic [SCC_NUM_SRC-1:0] osc_clk_in,
  input  wire logic                  primary_start_timer_expired,
  input  wire logic                  fast_rc_settled,
  input  wire logic                  secondary_oscillator_enable,
  input  wire logic                  sleep_request,
  input  wire logic                  wake_request,
  output logic      [1:0]            active_source,
  output logic                       clock_hold,
  output logic      [2:0]            clock_mode,
  output logic      [3:0]            fast_rc_postscale_shift,
  output logic      [5:0]            fast_rc_trim,
  output logic                       low_freq_source_select,
  output logic                       multiplier_active,
  output logic      [2:0]            clock_multiplier,
  output logic                       enter_sleep,
  output logic                       enter_idle,
  output logic                       power_managed,
  output logic                       secondary_clock_active,
  output logic                       slow_rc_enable,
  output logic                       secondary_keep_running
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic mult_available(input logic [2:0] cfg);
    mult_available = (cfg == SCC_CFG_HS_MULT) || (cfg == SCC_CFG_EC_MULT); // [RULE13]
  endfunction

  function automatic scc_src_t internal_src(input logic [2:0] div, input logic lf);
    // 000 without fast rc division falls to the slow rc
    if ((div == SCC_DIV_31KHZ) && !lf) begin // [RULE12]
      internal_src = SRC_SLOW_RC;
    end else begin
      internal_src = SRC_FAST_RC;
    end
  endfunction

  function automatic scc_src_t resolve_src(input logic [1:0] sel, input logic dflt,
                                           input logic [2:0] div, input logic lf);
    if (sel == SCC_SEL_INTERN) begin // [RULE8]
      resolve_src = internal_src(div, lf);
    end else if (sel == SCC_SEL_PRIMARY) begin
      resolve_src = SRC_PRIMARY;
    end else if (sel == SCC_SEL_SECOND) begin
      resolve_src = SRC_SECONDARY;
    end else if (dflt) begin // [RULE9]
      resolve_src = SRC_PRIMARY;
    end else begin
      resolve_src = internal_src(div, lf);
    end
  endfunction

  function automatic logic [3:0] postscale_shift(input logic [2:0] div);
    // 111 is divide by one; each step down halves, 000 divides by 256
    if (div == SCC_DIV_31KHZ) begin // [RULE3]
      postscale_shift = SCC_SHIFT_256;
    end else begin
      postscale_shift = {1'b0, SCC_DIV_8MHZ - div};
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  cfg_loaded;
    logic [2:0]            cfg_mode;
    logic                  cfg_default;
    logic                  cfg_two_speed;
    logic                  idle_sel;
    logic [2:0]            div_sel;
    logic [1:0]            src_sel;
    logic                  lf_sel;
    logic                  mult_sel;
    logic [5:0]            trim;
    logic                  pri_s1;
    logic                  pri_s2;
    logic                  rc_s1;
    logic                  rc_s2;
    logic                  init_phase;
    logic                  start_done;
    logic                  rc_stable;
    logic                  enter_sleep;
    logic                  enter_idle;
    logic                  pm;
    logic                  asleep;
    logic [SCC_DATA_W-1:0] rdata;
  } scc_state_t;

  scc_state_t st;
  scc_state_t next_st;

  scc_switch_if sw ();

  scc_edge_sync #(
    .N (SCC_NUM_SRC)
  ) u_edge_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .osc_clk  (osc_clk_in),
    .sw       (sw.edge_src)
  );

  scc_switch_seq u_switch_seq (
    .core_clk (core_clk),
    .reset    (reset),
    .sw       (sw.seq)
  );

  // ----------------------------------------------------------------
  // source target and readiness
  // ----------------------------------------------------------------
  scc_src_t        want_src;
  scc_src_t        target_src;
  logic            sec_running;
  logic            settled;
  logic [7:0]      control_view;
  logic [7:0]      tuning_view;

  assign sec_running = secondary_oscillator_enable;
  assign want_src    = resolve_src(st.src_sel, st.cfg_default, st.div_sel, st.lf_sel);
  // a disabled secondary oscillator cannot take over, so the request is dropped
  assign target_src  = ((want_src == SRC_SECONDARY) && !sec_running) ?
                       sw.active : want_src; // [RULE16]
  // software is expected to start the oscillator first; an enabled but slow one stalls here
  assign sw.src_ready = {1'b1, st.rc_stable, sec_running, st.pri_s2}; // [RULE17]
  assign sw.req       = st.cfg_loaded;
  assign sw.target    = target_src;
  assign settled      = st.cfg_loaded && !sw.busy && (sw.active == target_src);

  assign control_view = {st.idle_sel, st.div_sel, st.start_done, st.rc_stable, st.src_sel};
  assign tuning_view  = {st.lf_sel, st.mult_sel && mult_available(st.cfg_mode), st.trim};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st             = st;
    next_st.enter_sleep = 1'b0;
    next_st.enter_idle  = 1'b0;
    next_st.rdata       = '0;

    // straps are taken in on the first edge after reset release
    if (!st.cfg_loaded) begin
      next_st.cfg_loaded    = 1'b1;
      next_st.cfg_mode      = primary_mode_config;
      next_st.cfg_default   = default_clock_config;
      next_st.cfg_two_speed = two_speed_start_config;
    end

    next_st.pri_s1 = primary_start_timer_expired;
    next_st.pri_s2 = st.pri_s1;
    next_st.rc_s1  = fast_rc_settled;
    next_st.rc_s2  = st.rc_s1;
    next_st.rc_stable = st.rc_s2; // [RULE7]

    // until the first switch settles the bit shows the start-up choice
    if (!st.cfg_loaded) begin
      next_st.start_done = ~two_speed_start_config; // [RULE6]
    end else if (st.init_phase && !settled) begin
      next_st.start_done = ~st.cfg_two_speed; // [RULE6]
    end else begin
      next_st.init_phase = 1'b0;
      next_st.start_done = st.pri_s2 && (sw.active == SRC_PRIMARY) && !sw.busy; // [RULE5]
    end

    // register writes; status bits 3 and 2 ignore writes
    if (reg_write) begin
      if (reg_addr == SCC_CONTROL_ADDR) begin
        next_st.idle_sel = reg_wdata[SCC_IDLE_BIT];
        next_st.div_sel  = reg_wdata[SCC_DIV_LSB +: 3]; // [RULE4]
        next_st.src_sel  = reg_wdata[SCC_SRC_LSB +: 2]; // [RULE10]
      end else if (reg_addr == SCC_TUNING_ADDR) begin
        next_st.lf_sel   = reg_wdata[SCC_LF_BIT];
        next_st.mult_sel = reg_wdata[SCC_MULT_BIT];
        next_st.trim     = reg_wdata[SCC_TRIM_LSB +: 6]; // [RULE14]
      end
    end

    // reads answer in the next cycle; unmapped reads return zero
    if (reg_read) begin
      if (reg_addr == SCC_CONTROL_ADDR) begin
        next_st.rdata = control_view;
      end else if (reg_addr == SCC_TUNING_ADDR) begin
        next_st.rdata = tuning_view; // [RULE13]
      end
    end

    // sleep entry; a wake in the same cycle wins over a sleep request
    if (wake_request) begin
      next_st.pm     = 1'b0;
      next_st.asleep = 1'b0;
    end else if (sleep_request && !st.pm && !st.asleep) begin
      if (st.idle_sel) begin // [RULE2]
        next_st.enter_idle = 1'b1;
        next_st.pm         = 1'b1;
      end else begin
        next_st.enter_sleep = 1'b1;
        next_st.asleep      = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st         <= '0;
      st.div_sel <= SCC_DIV_RESET;
      st.src_sel <= SCC_SRC_RESET; // [RULE20]
      st.trim    <= SCC_TRIM_RESET;
      st.init_phase <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  scc_mode_t mode;

  always_comb begin
    if (sw.active == SRC_SLOW_RC) begin // [RULE1]
      mode = MODE_SLOW_RC;
    end else if ((sw.active == SRC_FAST_RC) || !st.cfg_loaded) begin
      mode = MODE_FAST_RC;
    end else if (st.cfg_mode[SCC_CFG_EC_BIT]) begin
      mode = mult_available(st.cfg_mode) ? MODE_EC_MULT : MODE_EC;
    end else begin
      mode = mult_available(st.cfg_mode) ? MODE_HS_MULT : MODE_HS;
    end
  end

  assign reg_rdata               = st.rdata;
  assign active_source           = sw.active;
  assign clock_hold              = sw.busy; // [RULE21]
  assign clock_mode              = mode;
  assign fast_rc_postscale_shift = postscale_shift(st.div_sel); // [RULE4]
  assign fast_rc_trim            = st.trim; // [RULE14]
  assign low_freq_source_select  = st.lf_sel; // [RULE12]
  assign multiplier_active       = st.mult_sel && mult_available(st.cfg_mode) &&
                                   (sw.active == SRC_PRIMARY); // [RULE22]
  assign clock_multiplier        = multiplier_active ? SCC_MULT_FACTOR : SCC_MULT_NONE; // [RULE22]
  assign enter_sleep             = st.enter_sleep;
  assign enter_idle              = st.enter_idle;
  assign power_managed           = st.pm;
  // once start-up ends the start-up bit needs primary active, so both flags are not set together
  assign secondary_clock_active  = (sw.active == SRC_SECONDARY) && !sw.busy; // [RULE15]
  // the slow rc never stops: watchdog and clock monitor depend on it
  assign slow_rc_enable          = 1'b1; // [RULE18]
  assign secondary_keep_running  = secondary_oscillator_enable; // [RULE19]

endmodule // scc_clock_select

// >>> verilog/scc_pkg.sv
// shared constants and types of the system clock select control
package scc_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int         SCC_ADDR_W       = 2;
  localparam int         SCC_DATA_W       = 8;
  localparam logic [1:0] SCC_CONTROL_ADDR = 2'h0;
  localparam logic [1:0] SCC_TUNING_ADDR  = 2'h1;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SCC_IDLE_BIT    = 7;
  localparam int SCC_DIV_LSB     = 4;
  localparam int SCC_START_BIT   = 3;
  localparam int SCC_STABLE_BIT  = 2;
  localparam int SCC_SRC_LSB     = 0;
  localparam int SCC_LF_BIT      = 7;
  localparam int SCC_MULT_BIT    = 6;
  localparam int SCC_TRIM_LSB    = 0;

  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] SCC_DIV_RESET   = 3'h4;
  localparam logic [1:0] SCC_SRC_RESET   = 2'h0;
  localparam logic [5:0] SCC_TRIM_RESET  = 6'h00;
  localparam logic [2:0] SCC_DIV_8MHZ    = 3'h7;
  localparam logic [2:0] SCC_DIV_31KHZ   = 3'h0;
  localparam logic [3:0] SCC_SHIFT_256   = 4'h8;
  localparam logic [1:0] SCC_SEL_DEFAULT = 2'h0;
  localparam logic [1:0] SCC_SEL_SECOND  = 2'h1;
  localparam logic [1:0] SCC_SEL_PRIMARY = 2'h2;
  localparam logic [1:0] SCC_SEL_INTERN  = 2'h3;
  localparam logic [2:0] SCC_CFG_HS_MULT = 3'h4;
  localparam logic [2:0] SCC_CFG_EC_MULT = 3'h6;
  localparam int         SCC_CFG_EC_BIT  = 1;
  localparam logic [2:0] SCC_MULT_FACTOR = 3'h4;
  localparam logic [2:0] SCC_MULT_NONE   = 3'h1;

  // ----------------------------------------------------------------
  // switch timing in source edges
  // ----------------------------------------------------------------
  localparam int         SCC_NUM_SRC   = 4;
  localparam logic [2:0] SCC_OLD_EDGES = 3'h2;
  localparam logic [2:0] SCC_NEW_EDGES = 3'h3;

  typedef enum logic [1:0] {
    SRC_PRIMARY, SRC_SECONDARY, SRC_FAST_RC, SRC_SLOW_RC
  } scc_src_t;

  typedef enum logic [2:0] {
    MODE_HS, MODE_HS_MULT, MODE_EC, MODE_EC_MULT, MODE_FAST_RC, MODE_SLOW_RC
  } scc_mode_t;

endpackage

// >>> verilog/scc_switch_if.sv
// carrier between the control top, the edge synchroniser and the switch sequencer
interface scc_switch_if
  import scc_pkg::*;
();
  logic [SCC_NUM_SRC-1:0] src_edge;
  logic [SCC_NUM_SRC-1:0] src_ready;
  logic                   req;
  scc_src_t               target;
  scc_src_t               active;
  logic                   busy;

  modport edge_src (output src_edge);
  modport seq      (input src_edge, src_ready, req, target, output active, busy);
  modport ctl      (output src_ready, req, target, input active, busy);
endinterface

// >>> verilog/scc_edge_sync.sv
// oscillator edge synchroniser into the core clock
module scc_edge_sync
  import scc_pkg::*;
#(
  parameter int N = SCC_NUM_SRC
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [N-1:0] osc_clk,
  scc_switch_if.edge_src    sw
);

  // one synchroniser lane per source; other counts cannot index the sequencer
  if (N != SCC_NUM_SRC) begin : g_bad_n
    $error("scc_edge_sync: N must equal the source count");
  end

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
  } scc_sync_t;

  scc_sync_t st;
  scc_sync_t next_st;

  // only s2 and s3 feed the edge detector, s1 is metastability-only
  always_comb begin
    next_st    = st;
    next_st.s1 = osc_clk;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sw.src_edge = st.s2 & ~st.s3; // [RULE23]

endmodule // scc_edge_sync

// >>> verilog/scc_switch_seq.sv
// glitch-free source switch sequencer
module scc_switch_seq
  import scc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset,
  scc_switch_if.seq sw
);

  typedef enum logic [1:0] {PH_IDLE, PH_DRAIN_OLD, PH_WAIT_NEW} scc_phase_t;

  typedef struct packed {
    scc_phase_t phase;
    logic [2:0] cnt;
    scc_src_t   active;
    scc_src_t   target;
  } scc_seq_t;

  scc_seq_t st;
  scc_seq_t next_st;

  always_comb begin
    next_st = st;
    case (st.phase)
      PH_IDLE: begin
        if (sw.req && (sw.target != st.active)) begin // [RULE10]
          next_st.phase  = PH_DRAIN_OLD;
          next_st.cnt    = 3'h0;
          next_st.target = sw.target;
        end
      end
      PH_DRAIN_OLD: begin
        // two edges of the old source let its current phase finish
        if (sw.src_edge[st.active]) begin // [RULE21]
          if (st.cnt == SCC_OLD_EDGES - 3'h1) begin
            next_st.phase = PH_WAIT_NEW;
            next_st.cnt   = 3'h0;
          end else begin
            next_st.cnt = st.cnt + 3'h1;
          end
        end
      end
      PH_WAIT_NEW: begin
        // new edges count only once the new source is stable
        if (sw.src_edge[st.target] && sw.src_ready[st.target]) begin // [RULE21]
          if (st.cnt == SCC_NEW_EDGES - 3'h1) begin
            next_st.phase  = PH_IDLE;
            next_st.active = st.target; // [RULE11]
          end else begin
            next_st.cnt = st.cnt + 3'h1;
          end
        end
      end
      default: begin
        next_st.phase = PH_IDLE;
      end
    endcase
  end

  // slow rc clocks the part from reset until the first switch completes
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st <= '{phase: PH_IDLE, cnt: 3'h0, active: SRC_SLOW_RC, target: SRC_SLOW_RC};
    end else begin
      st <= next_st;
    end
  end

  assign sw.active = st.active;
  assign sw.busy   = (st.phase != PH_IDLE);

endmodule // scc_switch_seq

// >>> verif/scc_clock_select_checker.sv
// concurrent checks on the ports of the system clock select control
module scc_clock_select_checker
  import scc_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic       sleep_request,
  input wire logic       wake_request,
  input wire logic       enter_idle,
  input wire logic       enter_sleep,
  input wire logic       power_managed,
  input wire logic       multiplier_active,
  input wire logic [2:0] clock_multiplier,
  input wire logic [2:0] primary_mode_config,
  input wire logic [1:0] active_source,
  input wire logic       clock_hold,
  input wire logic       secondary_clock_active,
  input wire logic       slow_rc_enable,
  input wire logic       secondary_keep_running,
  input wire logic       secondary_oscillator_enable
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // sleep entry
  // ----------------------------------------------------------------
  a_sleep_one_pulse: assert property (sleep_request && !power_managed && !wake_request
    |=> (enter_idle != enter_sleep) ##1 !(enter_idle || enter_sleep))
    else $error("sleep request did not give one single pulse");
  a_idle_sets_pm: assert property (enter_idle |-> power_managed)
    else $error("idle entry without power managed state");
  a_wake_clears_pm: assert property (wake_request |=> !power_managed && !enter_idle)
    else $error("wake did not leave power managed state");

  // ----------------------------------------------------------------
  // multiplier and source switch
  // ----------------------------------------------------------------
  a_mult_factor: assert property (clock_multiplier == (multiplier_active ? 3'h4 : 3'h1))
    else $error("multiplier factor wrong");
  a_mult_mode_only: assert property (multiplier_active
    |-> primary_mode_config[2] && active_source == 2'h0)
    else $error("multiplier active outside multiplied primary mode");
  a_src_moves_late: assert property ($changed(active_source) |-> $fell(clock_hold))
    else $error("source changed outside end of switch");
  a_hold_min_span: assert property ($rose(clock_hold) |=> clock_hold [*4])
    else $error("switch pause too short");
  a_second_status: assert property (secondary_clock_active
    == (active_source == 2'h1 && !clock_hold))
    else $error("secondary active flag wrong");
  a_slow_rc_on: assert property (slow_rc_enable)
    else $error("slow rc stopped");
  a_second_runs: assert property (secondary_keep_running == secondary_oscillator_enable)
    else $error("secondary keep running wrong");
endmodule // scc_clock_select_checker

bind scc_clock_select scc_clock_select_checker i_scc_clock_select_checker (
  .core_clk, .reset, .sleep_request, .wake_request, .enter_idle, .enter_sleep,
  .power_managed, .multiplier_active, .clock_multiplier, .primary_mode_config,
  .active_source, .clock_hold, .secondary_clock_active, .slow_rc_enable,
  .secondary_keep_running, .secondary_oscillator_enable);

// >>> verif/tb.sv
// self-checking bench of the system clock select control
module tb
  import scc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk = 1'b0;
  logic       reset = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic [2:0] primary_mode_config = 3'h4;
  logic       default_clock_config = 1'b1;
  logic       two_speed_start_config = 1'b0;
  logic [3:0] osc_clk_in = 4'h0;
  logic       primary_start_timer_expired = 1'b1;
  logic       fast_rc_settled = 1'b0;
  logic       secondary_oscillator_enable = 1'b0;
  logic       sleep_request = 1'b0;
  logic       wake_request = 1'b0;
  logic [7:0] reg_rdata, osc_count = 8'h00;
  logic [1:0] active_source;
  logic [2:0] clock_mode, clock_multiplier;
  logic [3:0] fast_rc_postscale_shift;
  logic [5:0] fast_rc_trim;
  logic       clock_hold, low_freq_source_select, multiplier_active, enter_sleep, enter_idle;
  logic       power_managed, secondary_clock_active, slow_rc_enable, secondary_keep_running;
  int         fail_count = 0;
  int         compares = 0;

  scc_clock_select i_scc_clock_select (
    .core_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .primary_mode_config, .default_clock_config, .two_speed_start_config, .osc_clk_in,
    .primary_start_timer_expired, .fast_rc_settled, .secondary_oscillator_enable,
    .sleep_request, .wake_request, .active_source, .clock_hold, .clock_mode,
    .fast_rc_postscale_shift, .fast_rc_trim, .low_freq_source_select, .multiplier_active,
    .clock_multiplier, .enter_sleep, .enter_idle, .power_managed, .secondary_clock_active,
    .slow_rc_enable, .secondary_keep_running);

  // ----------------------------------------------------------------
  // clock and oscillator levels
  // ----------------------------------------------------------------
  always #4 core_clk = ~core_clk;
  // slow rc slowest so a switch to or from it takes longest
  always @(posedge core_clk) begin
    osc_count <= osc_count + 8'h01;
    osc_clk_in <= {osc_count[4], osc_count[2], osc_count[3], osc_count[1]};
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rchk(input logic [1:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // bounded wait; running out shows as a mismatch
  task automatic wait_hold(input logic v, input int lim);
    int n;
    n = 0;
    #1;
    while (clock_hold !== v && n < lim) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(clock_hold, v);
  endtask
  task automatic sleep_go(input logic [1:0] exp);
    @(posedge core_clk);
    sleep_request <= 1'b1;
    @(posedge core_clk);
    sleep_request <= 1'b0;
    #1;
    chk({enter_idle, enter_sleep}, exp);
  endtask
  task automatic wake();
    @(posedge core_clk);
    wake_request <= 1'b1;
    @(posedge core_clk);
    wake_request <= 1'b0;
    #1;
    chk(power_managed, 1'b0);
  endtask
  task automatic report_and_stop();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    chk(active_source, 2'h3);
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rchk(SCC_CONTROL_ADDR, 8'h48);
    rchk(SCC_TUNING_ADDR, 8'h00);
    rchk(2'h2, 8'h00);
    wait_hold(1'b1, 8);
    wait_hold(1'b0, 400);
    chk(active_source, 2'h0);
    chk(clock_mode, 3'h1);
    wr(2'h3, 8'hFF);
    wr(SCC_CONTROL_ADDR, 8'h4C);
    rchk(SCC_CONTROL_ADDR, 8'h48);
    wr(SCC_TUNING_ADDR, 8'hDF);
    rchk(SCC_TUNING_ADDR, 8'hDF);
    chk({low_freq_source_select, multiplier_active, fast_rc_trim}, 8'hDF);
    chk(clock_multiplier, 3'h4);
    wr(SCC_TUNING_ADDR, 8'h20);
    rchk(SCC_TUNING_ADDR, 8'h20);
    chk(clock_multiplier, 3'h1);
    @(posedge core_clk);
    fast_rc_settled <= 1'b1;
    wr(SCC_CONTROL_ADDR, 8'h73);
    wait_hold(1'b1, 3);
    wait_hold(1'b0, 400);
    chk(active_source, 2'h2);
    chk(clock_mode, 3'h4);
    rchk(SCC_CONTROL_ADDR, 8'h77);
    // divide by 256 on the lowest step keeps the fast rc running
    wr(SCC_TUNING_ADDR, 8'h80);
    for (int d = 7; d >= 0; d--) begin
      wr(SCC_CONTROL_ADDR, {1'b0, d[2:0], 4'h3});
      #1;
      chk(fast_rc_postscale_shift, (d == 0) ? 4'h8 : 4'(7 - d));
      chk(clock_hold, 1'b0);
    end
    wr(SCC_CONTROL_ADDR, 8'h71);
    repeat (20) @(posedge core_clk);
    #1;
    chk(clock_hold, 1'b0);
    chk(active_source, 2'h2);
    @(posedge core_clk);
    secondary_oscillator_enable <= 1'b1;
    wr(SCC_CONTROL_ADDR, 8'h71);
    wait_hold(1'b1, 8);
    wait_hold(1'b0, 400);
    chk({active_source, secondary_clock_active}, 3'h3);
    wr(SCC_CONTROL_ADDR, 8'hC2);
    wait_hold(1'b1, 3);
    wait_hold(1'b0, 400);
    chk(active_source, 2'h0);
    rchk(SCC_CONTROL_ADDR, 8'hCE);
    sleep_go(2'b10);
    chk(power_managed, 1'b1);
    sleep_go(2'b00);
    wake();
    wr(SCC_CONTROL_ADDR, 8'h42);
    sleep_go(2'b01);
    wake();
    wr(SCC_CONTROL_ADDR, 8'h43);
    @(posedge core_clk);
    reset <= 1'b1;
    two_speed_start_config <= 1'b1;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rchk(SCC_CONTROL_ADDR, 8'h40);
    chk(active_source, 2'h3);
    report_and_stop();
  end
endmodule // tb
